//--- src/mid_defines.svh
// Constants for the module identification and diagnostics serial slave
`ifndef MID_DEFINES_SVH
`define MID_DEFINES_SVH

// ----------------------------------------------------------------------------
// Bus addresses (7-bit device part of the 8-bit address byte)
// ----------------------------------------------------------------------------
`define MID_ID_DEV      7'h50
`define MID_DIAG_DEV    7'h51
`define MID_PAGE_BYTES  256
`define MID_BYTE_BITS   4'h8

// ----------------------------------------------------------------------------
// Diagnostics page layout
// ----------------------------------------------------------------------------
`define MID_LIVE_BASE   8'h60
`define MID_LIVE_END    8'h69
`define MID_FLAG_ALM_HI 8'h70
`define MID_FLAG_ALM_LO 8'h71
`define MID_FLAG_WRN_HI 8'h74
`define MID_FLAG_WRN_LO 8'h75
`define MID_WR_LO       8'h80
`define MID_WR_HI       8'hf7

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define MID_CLK_MHZ     10
`define MID_TXOFF_US    10
`define MID_TXOFF_CYC   (`MID_TXOFF_US * `MID_CLK_MHZ)

`endif

//--- src/mid_mem.sv
// Byte memory holding the identification and diagnostics pages
`timescale 1ns/1ps

module mid_mem #(
    parameter int AW = 9,
    parameter int DW = 8
) (
    // Clock and reset
    input  wire logic          mclk,
    input  wire logic          rstn,
    // Write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    // Read port
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata_q
);

    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge mclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= mem[raddr];
        end
    end

endmodule // mid_mem

//--- src/mid_pkg.sv
// Types for the module identification and diagnostics serial slave
package mid_pkg;

    // Gray coded along address, ack, data
    typedef enum logic [3:0] {
        MID_IDLE  = 4'h0,
        MID_ADDR  = 4'h1,
        MID_ACK_A = 4'h3,
        MID_WADR  = 4'h2,
        MID_ACK_W = 4'h6,
        MID_WDAT  = 4'h7,
        MID_RD    = 4'h5,
        MID_RACK  = 4'h4
    } mid_state_t;

endpackage

//--- src/mid_serial_slave.sv
// Two-wire serial slave serving identification and diagnostics pages
//
// Contract
// - Answer at A0h with 256-byte identification page
// - Answer at A2h with separate diagnostics page
// - Sample on clock rise; store only unprotected bytes
// - Change read data bit on clock fall
// - Byte words, single and sequential access
// - Report calibrated live diagnostics values
// - Flag parameters outside factory normal range
// - No-light output 0 normal, 1 no signal
// - Transmitter off within 10 us of disable
// - Module present pin held at ground
`timescale 1ns/1ps
`include "mid_defines.svh"

module mid_serial_slave
    import mid_pkg::*;
#(
    parameter logic [15:0] HI_ALM = 16'hf000,
    parameter logic [15:0] HI_WRN = 16'he000,
    parameter logic [15:0] LO_WRN = 16'h1000,
    parameter logic [15:0] LO_ALM = 16'h0800
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rstn,
    // Two-wire bus pins
    input  wire logic        scl,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    // Calibrated monitor values
    input  wire logic [15:0] temp_value,
    input  wire logic [15:0] vcc_value,
    input  wire logic [15:0] bias_value,
    input  wire logic [15:0] txpwr_value,
    input  wire logic [15:0] rxpwr_value,
    // Status flags, one bit per monitored value
    output logic      [4:0]  alarm_hi,
    output logic      [4:0]  alarm_lo,
    output logic      [4:0]  warn_hi,
    output logic      [4:0]  warn_lo,
    // Optics control pins
    input  wire logic        transmit_off_level,
    input  wire logic        light_detect,
    output logic             laser_on,
    output logic             no_light_flag,
    output logic             module_present_pin
);

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    logic [2:0] scl_q;
    logic [2:0] sda_q;
    logic [1:0] txoff_q;
    logic [1:0] light_q;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            scl_q   <= 3'h7;
            sda_q   <= 3'h7;
            txoff_q <= 2'h3;
            light_q <= 2'h0;
        end else begin
            scl_q   <= {scl_q[1:0], scl};
            sda_q   <= {sda_q[1:0], sda_i};
            txoff_q <= {txoff_q[0], transmit_off_level};
            light_q <= {light_q[0], light_detect};
        end
    end

    // Edges are judged on stages two and three only
    wire scl_rise = scl_q[1] & ~scl_q[2];
    wire scl_fall = ~scl_q[1] & scl_q[2];
    wire sda_bit  = sda_q[1];
    wire start_ev = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
    wire stop_ev  = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];

    // ------------------------------------------------------------------------
    // Transfer state
    // ------------------------------------------------------------------------
    mid_state_t  state_q;
    logic [3:0]  cnt_q;
    logic [7:0]  shift_q;
    logic [7:0]  tx_q;
    logic [7:0]  ptr_q;
    logic        page_q;
    logic        rnw_q;
    logic        nack_q;
    logic        oe_q;

    wire byte_done = scl_fall && (cnt_q == `MID_BYTE_BITS);
    wire dev_id    = shift_q[7:1] == `MID_ID_DEV;
    wire dev_diag  = shift_q[7:1] == `MID_DIAG_DEV;

    // Only the user block of the diagnostics page takes writes
    wire writable  = page_q && (ptr_q >= `MID_WR_LO) && (ptr_q <= `MID_WR_HI);
    wire mem_we    = (state_q == MID_WDAT) && byte_done && writable;

    // ------------------------------------------------------------------------
    // Read byte selection
    // ------------------------------------------------------------------------
    logic [15:0] diag_w [5];
    logic [7:0]  mem_rdata;

    assign diag_w[0] = temp_value;
    assign diag_w[1] = vcc_value;
    assign diag_w[2] = bias_value;
    assign diag_w[3] = txpwr_value;
    assign diag_w[4] = rxpwr_value;

    wire        live_hit = page_q && (ptr_q >= `MID_LIVE_BASE) && (ptr_q <= `MID_LIVE_END);
    wire [7:0]  live_off = ptr_q - `MID_LIVE_BASE;
    wire [2:0]  live_idx = live_off[3:1];
    wire [15:0] live_val = diag_w[live_idx];
    wire [7:0]  live_byte = ptr_q[0] ? live_val[7:0] : live_val[15:8];

    wire [7:0]  flag_byte =
        (ptr_q == `MID_FLAG_ALM_HI) ? {alarm_hi, 3'h0} :
        (ptr_q == `MID_FLAG_ALM_LO) ? {alarm_lo, 3'h0} :
        (ptr_q == `MID_FLAG_WRN_HI) ? {warn_hi, 3'h0}  :
                                      {warn_lo, 3'h0};
    wire        flag_hit = page_q && ((ptr_q == `MID_FLAG_ALM_HI) ||
                           (ptr_q == `MID_FLAG_ALM_LO) || (ptr_q == `MID_FLAG_WRN_HI) ||
                           (ptr_q == `MID_FLAG_WRN_LO));
    wire [7:0]  rd_byte  = live_hit ? live_byte : flag_hit ? flag_byte : mem_rdata;

    mid_mem #(
        .AW (9),
        .DW (8)
    ) u_mem (
        .mclk    (mclk),
        .rstn    (rstn),
        .we      (mem_we),
        .waddr   ({page_q, ptr_q}),
        .wdata   (shift_q),
        .raddr   ({page_q, ptr_q}),
        .rdata_q (mem_rdata)
    );

    // ------------------------------------------------------------------------
    // Receive shifter and acknowledge sample
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            shift_q <= 8'h00;
            nack_q  <= 1'b0;
        end else if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_bit};
            nack_q  <= sda_bit;
        end
    end

    // ------------------------------------------------------------------------
    // Protocol machine
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_q <= MID_IDLE;
            cnt_q   <= 4'h0;
            tx_q    <= 8'h00;
            ptr_q   <= 8'h00;
            page_q  <= 1'b0;
            rnw_q   <= 1'b0;
            oe_q    <= 1'b0;
        end else if (start_ev) begin
            // Repeated start keeps the pointer for a random read
            state_q <= MID_ADDR;
            cnt_q   <= 4'h0;
            oe_q    <= 1'b0;
        end else if (stop_ev) begin
            state_q <= MID_IDLE;
            oe_q    <= 1'b0;
        end else begin
            if (scl_rise) begin
                cnt_q <= cnt_q + 4'h1;
            end
            case (state_q)
                MID_ADDR: begin
                    if (byte_done) begin
                        if (dev_id || dev_diag) begin
                            page_q  <= dev_diag;
                            rnw_q   <= shift_q[0];
                            oe_q    <= 1'b1;
                            state_q <= MID_ACK_A;
                        end else begin
                            state_q <= MID_IDLE;
                        end
                    end
                end
                MID_ACK_A: begin
                    if (scl_fall) begin
                        cnt_q <= 4'h0;
                        if (rnw_q) begin
                            tx_q    <= rd_byte;
                            oe_q    <= ~rd_byte[7];
                            state_q <= MID_RD;
                        end else begin
                            oe_q    <= 1'b0;
                            state_q <= MID_WADR;
                        end
                    end
                end
                MID_WADR: begin
                    if (byte_done) begin
                        ptr_q   <= shift_q;
                        oe_q    <= 1'b1;
                        state_q <= MID_ACK_W;
                    end
                end
                MID_ACK_W: begin
                    if (scl_fall) begin
                        cnt_q   <= 4'h0;
                        oe_q    <= 1'b0;
                        state_q <= MID_WDAT;
                    end
                end
                MID_WDAT: begin
                    if (byte_done) begin
                        ptr_q   <= ptr_q + 8'h01;
                        oe_q    <= 1'b1;
                        state_q <= MID_ACK_W;
                    end
                end
                MID_RD: begin
                    if (byte_done) begin
                        ptr_q   <= ptr_q + 8'h01;
                        oe_q    <= 1'b0;
                        state_q <= MID_RACK;
                    end else if (scl_fall) begin
                        tx_q <= {tx_q[6:0], 1'b0};
                        oe_q <= ~tx_q[6];
                    end
                end
                MID_RACK: begin
                    if (scl_fall) begin
                        cnt_q <= 4'h0;
                        if (nack_q) begin
                            state_q <= MID_IDLE;
                        end else begin
                            tx_q    <= rd_byte;
                            oe_q    <= ~rd_byte[7];
                            state_q <= MID_RD;
                        end
                    end
                end
                default: begin
                    state_q <= MID_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Range flags
    // ------------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < 5; i++) begin : g_flag
            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    alarm_hi[i] <= 1'b0;
                    alarm_lo[i] <= 1'b0;
                    warn_hi[i]  <= 1'b0;
                    warn_lo[i]  <= 1'b0;
                end else begin
                    alarm_hi[i] <= diag_w[i] > HI_ALM;
                    alarm_lo[i] <= diag_w[i] < LO_ALM;
                    warn_hi[i]  <= diag_w[i] > HI_WRN;
                    warn_lo[i]  <= diag_w[i] < LO_WRN;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Pin outputs
    // ------------------------------------------------------------------------
    // Disable path is three cycles, far inside the MID_TXOFF_CYC budget
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sda_o              <= 1'b0;
            sda_oe             <= 1'b0;
            laser_on           <= 1'b0;
            no_light_flag      <= 1'b1;
            module_present_pin <= 1'b0;
        end else begin
            sda_o              <= 1'b0;
            sda_oe             <= oe_q;
            laser_on           <= ~txoff_q[1];
            no_light_flag      <= ~light_q[1];
            module_present_pin <= 1'b0;
        end
    end

endmodule // mid_serial_slave

//--- testbench/mid_host.sv
// Two-wire bus host model making the serial clock and framing transfers
`timescale 1ns/1ps

module mid_host (
    // Clock
    input  wire logic mclk,
    // Bus
    input  wire logic sda,
    output logic      scl,
    output logic      sda_pull
);
    // Bus clock idles high outside frames
    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // Data moves only in the low phase; sampled as the clock rises.
    // Low phase is the longer one so the slave's synchronised answer
    // settles a full cycle before the rise.
    task automatic bitx(input logic b, output logic r);
        tick(2);
        sda_pull = !b;
        tick(3);
        r = sda;
        scl = 1'b1;
        tick(3);
        scl = 1'b0;
    endtask

    task automatic start();
        tick(2);
        sda_pull = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_pull = 1'b1;
        tick(4);
        scl = 1'b0;
    endtask

    task automatic stop();
        tick(2);
        sda_pull = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(4);
        sda_pull = 1'b0;
        tick(4);
    endtask

    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(b[i], r);
        bitx(1'b1, r);
        ack = !r;
    endtask

    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, r);
            d[i] = r;
        end
        bitx(last, r);
    endtask
endmodule // mid_host

//--- testbench/mid_serial_slave_assertions.sv
// Checker for the identification and diagnostics serial slave
`timescale 1ns/1ps

module mid_serial_slave_assertions #(
    parameter logic [15:0] HI_ALM = 16'hf000,
    parameter logic [15:0] HI_WRN = 16'he000,
    parameter logic [15:0] LO_WRN = 16'h1000,
    parameter logic [15:0] LO_ALM = 16'h0800
) (
    // Clock, reset and bus
    input wire logic        mclk,
    input wire logic        rstn,
    input wire logic        scl,
    input wire logic        sda_oe,
    // Monitors and flags
    input wire logic [15:0] temp_value,
    input wire logic [15:0] vcc_value,
    input wire logic [15:0] bias_value,
    input wire logic [15:0] txpwr_value,
    input wire logic [15:0] rxpwr_value,
    input wire logic [4:0]  alarm_hi,
    input wire logic [4:0]  alarm_lo,
    input wire logic [4:0]  warn_hi,
    input wire logic [4:0]  warn_lo,
    // Optics
    input wire logic        transmit_off_level,
    input wire logic        light_detect,
    input wire logic        laser_on,
    input wire logic        no_light_flag,
    input wire logic        module_present_pin
);
    logic [79:0] vals;
    logic [4:0]  ex_ah, ex_al, ex_wh, ex_wl;

    assign vals = {rxpwr_value, txpwr_value, bias_value, vcc_value, temp_value};

    always_comb begin
        for (int i = 0; i < 5; i++) begin
            ex_ah[i] = vals[16*i +: 16] > HI_ALM;
            ex_wh[i] = vals[16*i +: 16] > HI_WRN;
            ex_al[i] = vals[16*i +: 16] < LO_ALM;
            ex_wl[i] = vals[16*i +: 16] < LO_WRN;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    present_low_a: assert property (module_present_pin == 1'b0)
        else $error("present pin not low");
    bit_launch_a: assert property ($rose(sda_oe) |-> !scl)
        else $error("data driven while bus clock high");
    laser_off_a: assert property (transmit_off_level [*4] |-> !laser_on)
        else $error("laser on while disabled");
    laser_on_a: assert property (!transmit_off_level [*4] |-> laser_on)
        else $error("laser off while enabled");
    no_light_a: assert property (!light_detect [*4] |-> no_light_flag)
        else $error("no-light flag low without light");
    light_ok_a: assert property (light_detect [*4] |-> !no_light_flag)
        else $error("no-light flag high with light");
    alarm_high_a: assert property ($past(rstn) && $stable(vals) |-> alarm_hi == ex_ah)
        else $error("high alarm flags wrong");
    alarm_low_a: assert property ($past(rstn) && $stable(vals) |-> alarm_lo == ex_al)
        else $error("low alarm flags wrong");
    warn_high_a: assert property ($past(rstn) && $stable(vals) |-> warn_hi == ex_wh)
        else $error("high warning flags wrong");
    warn_low_a: assert property ($past(rstn) && $stable(vals) |-> warn_lo == ex_wl)
        else $error("low warning flags wrong");
endmodule // mid_serial_slave_assertions

bind mid_serial_slave mid_serial_slave_assertions #(
    .HI_ALM(HI_ALM), .HI_WRN(HI_WRN), .LO_WRN(LO_WRN), .LO_ALM(LO_ALM)
) chk_inst (
    .mclk(mclk), .rstn(rstn), .scl(scl), .sda_oe(sda_oe),
    .temp_value(temp_value), .vcc_value(vcc_value), .bias_value(bias_value),
    .txpwr_value(txpwr_value), .rxpwr_value(rxpwr_value),
    .alarm_hi(alarm_hi), .alarm_lo(alarm_lo), .warn_hi(warn_hi), .warn_lo(warn_lo),
    .transmit_off_level(transmit_off_level), .light_detect(light_detect),
    .laser_on(laser_on), .no_light_flag(no_light_flag),
    .module_present_pin(module_present_pin)
);

//--- testbench/mid_serial_slave_tb.sv
// Self-checking bench for the identification and diagnostics serial slave
`timescale 1ns/1ps

module mid_serial_slave_tb;
    logic        mclk = 1'b0;
    logic        rstn, scl, sda_pull, sda_o, sda_oe;
    wire         sda;
    logic [15:0] temp_value, vcc_value, bias_value, txpwr_value, rxpwr_value;
    logic [4:0]  alarm_hi, alarm_lo, warn_hi, warn_lo;
    logic        transmit_off_level, light_detect, laser_on, no_light_flag;
    logic        module_present_pin;
    logic [7:0]  d0, d1;
    logic        a1, a2;
    int          fails = 0;
    int          n_tests = 0;

    // Pull-up on the data line: low while either party pulls
    assign sda = !(sda_pull || (sda_oe && !sda_o));
    always #50 mclk = ~mclk;

    mid_serial_slave mid_serial_slave_inst (
        .mclk(mclk), .rstn(rstn), .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .temp_value(temp_value), .vcc_value(vcc_value), .bias_value(bias_value),
        .txpwr_value(txpwr_value), .rxpwr_value(rxpwr_value),
        .alarm_hi(alarm_hi), .alarm_lo(alarm_lo), .warn_hi(warn_hi), .warn_lo(warn_lo),
        .transmit_off_level(transmit_off_level), .light_detect(light_detect),
        .laser_on(laser_on), .no_light_flag(no_light_flag),
        .module_present_pin(module_present_pin)
    );
    mid_host mid_host_inst (.mclk(mclk), .sda(sda), .scl(scl), .sda_pull(sda_pull));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic chk(input logic ok, input string msg);
        n_tests++;
        if (!ok) begin
            fails++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask

    task automatic head(input logic [7:0] dev, input logic [7:0] adr);
        mid_host_inst.start();
        mid_host_inst.wbyte(dev, a1);
        mid_host_inst.wbyte(adr, a2);
        chk((a1 & a2) === 1'b1, "header not acknowledged");
    endtask

    task automatic rd2(input logic [7:0] dev, input logic [7:0] adr);
        head(dev, adr);
        mid_host_inst.start();
        mid_host_inst.wbyte(dev | 8'h01, a1);
        mid_host_inst.rbyte(1'b0, d0);
        mid_host_inst.rbyte(1'b1, d1);
        mid_host_inst.stop();
        chk(a1 === 1'b1, "read address not acknowledged");
    endtask

    task automatic wr2(input logic [7:0] dev, input logic [7:0] adr, input logic [15:0] v);
        head(dev, adr);
        mid_host_inst.wbyte(v[15:8], a1);
        mid_host_inst.wbyte(v[7:0], a2);
        mid_host_inst.stop();
        chk((a1 & a2) === 1'b1, "data not acknowledged");
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_optics();
        chk(module_present_pin === 1'b0, "present pin");
        transmit_off_level = 1'b0;
        light_detect = 1'b0;
        tick(100);
        chk(laser_on === 1'b1, "laser not on");
        chk(no_light_flag === 1'b1, "no-light flag low");
        transmit_off_level = 1'b1;
        light_detect = 1'b1;
        tick(100);
        chk(laser_on === 1'b0, "laser not off in time");
        chk(no_light_flag === 1'b0, "no-light flag high");
        $display("test optics done");
    endtask

    task automatic t_flags();
        temp_value = 16'hf812;
        vcc_value = 16'h0400;
        bias_value = 16'h0c00;
        txpwr_value = 16'he800;
        tick(4);
        chk(alarm_hi === 5'b00001, "high alarms");
        chk(warn_hi === 5'b01001, "high warnings");
        chk(alarm_lo === 5'b00010, "low alarms");
        chk(warn_lo === 5'b00110, "low warnings");
        rd2(8'ha2, 8'h70);
        chk(d0 === 8'h08, "high alarm byte");
        chk(d1 === 8'h10, "low alarm byte");
        rd2(8'ha2, 8'h74);
        chk(d0 === 8'h48, "high warning byte");
        chk(d1 === 8'h30, "low warning byte");
        rd2(8'ha2, 8'h68);
        chk({d0, d1} === rxpwr_value, "receive power value");
        $display("test flags done");
    endtask

    task automatic t_seq();
        wr2(8'ha2, 8'h80, 16'h5ac3);
        rd2(8'ha2, 8'h80);
        chk(d0 === 8'h5a, "first byte");
        chk(d1 === 8'hc3, "second byte");
        $display("test sequential done");
    endtask

    task automatic t_prot();
        wr2(8'ha2, 8'h60, 16'h0000);
        rd2(8'ha2, 8'h60);
        chk(d0 === temp_value[15:8], "live value high byte");
        chk(d1 === temp_value[7:0], "live value low byte");
        wr2(8'ha2, 8'hf7, 16'h1122);
        rd2(8'ha2, 8'hf7);
        chk(d0 === 8'h11, "last writable byte");
        chk(d1 !== 8'h22, "protected byte stored");
        wr2(8'ha0, 8'h10, 16'h3344);
        rd2(8'ha0, 8'h10);
        chk(d0 !== 8'h33, "identification page written");
        $display("test protection done");
    endtask

    task automatic t_nack();
        mid_host_inst.start();
        mid_host_inst.wbyte(8'ha4, a1);
        mid_host_inst.stop();
        chk(a1 === 1'b0, "foreign address acknowledged");
        $display("test foreign address done");
    endtask

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        rstn = 1'b0;
        transmit_off_level = 1'b1;
        light_detect = 1'b1;
        {temp_value, vcc_value, bias_value, txpwr_value, rxpwr_value} = {5{16'h8000}};
        repeat (8) @(posedge mclk);
        #1 rstn = 1'b1;
        tick(8);
        t_optics();
        t_flags();
        t_seq();
        t_prot();
        t_nack();
        wrap_up();
    end

    // About 4300 cycles are needed; cut a hang at well over six times that
    initial begin
        repeat (30000) @(posedge mclk);
        fails++;
        wrap_up();
    end
endmodule // mid_serial_slave_tb
